// ---- rtl/iq_corr_pkg.sv ----
package iq_corr_pkg;
    // widths
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam int SMP_W     = 16;
    localparam int OFF_W     = 13;
    localparam int GAIN_W    = 11;
    localparam int CMIX_W    = 4;
    localparam int SHIFT_W   = 3;
    localparam int GAIN_FRAC = 10;
    localparam int NCH       = 4;
    // channel indices
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_C = 2;
    localparam int CH_D = 3;
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_OFF_C       = 8'h0A;
    localparam logic [ADDR_W-1:0] ADDR_OFF_D       = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_A      = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CMIX_GAIN_B = 8'h0D;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_C      = 8'h0E;
    // field positions
    localparam int OFF_MSB  = 12;
    localparam int GAIN_MSB = 10;
    localparam int CMIX_MSB = 15;
    localparam int CMIX_LSB = 12;
    // bit of each mixer inside the coarse mix field
    localparam int CMIX_FS8  = 3;
    localparam int CMIX_FS4  = 2;
    localparam int CMIX_FS2  = 1;
    localparam int CMIX_NFS4 = 0;
    // shift of each mixer in units of fs/8, modulo 8
    localparam logic [SHIFT_W-1:0] W_FS8  = 3'h1;
    localparam logic [SHIFT_W-1:0] W_FS4  = 3'h2;
    localparam logic [SHIFT_W-1:0] W_FS2  = 3'h4;
    localparam logic [SHIFT_W-1:0] W_NFS4 = 3'h6;
    localparam logic [SHIFT_W-1:0] SHIFT_NONE = 3'h0;
    // reset values
    localparam logic [OFF_W-1:0]  OFF_RST  = 13'h0000;
    localparam logic [GAIN_W-1:0] GAIN_RST = 11'h400;
    localparam logic [CMIX_W-1:0] CMIX_RST = 4'h0;
    localparam logic [DATA_W-1:0] RD_ZERO  = 16'h0000;
    // sample limits
    localparam logic signed [SMP_W-1:0] SMP_MAX = 16'sh7FFF;
    localparam logic signed [SMP_W-1:0] SMP_MIN = -16'sh8000;
endpackage

// ---- rtl/gain_scale.sv ----
`timescale 1ns/1ps
module gain_scale (
    input  wire logic                       clk_sys_i, // system clock
    input  wire logic                       sys_rst_i, // sync reset
    input  wire logic                       ce_i,      // clock enable
    input  wire logic signed [15:0]         smp_i,     // input sample
    input  wire logic [10:0]                gain_i,    // 1.10 unsigned
    output logic signed [15:0]              smp_o      // scaled sample
);
    logic signed [27:0] prod;
    logic signed [27:0] shf;

    // unsigned factor, binary point between bits 9 and 10
    assign prod = smp_i * $signed({1'b0, gain_i});
    assign shf  = prod >>> iq_corr_pkg::GAIN_FRAC;

    // saturate into the sample range
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            smp_o <= '0;
        end else if (ce_i) begin
            if (shf > 28'(iq_corr_pkg::SMP_MAX)) begin
                smp_o <= iq_corr_pkg::SMP_MAX;
            end else if (shf < 28'(iq_corr_pkg::SMP_MIN)) begin
                smp_o <= iq_corr_pkg::SMP_MIN;
            end else begin
                smp_o <= shf[15:0];
            end
        end
    end
endmodule

// ---- rtl/offset_sat.sv ----
`timescale 1ns/1ps
module offset_sat (
    input  wire logic                       clk_sys_i, // system clock
    input  wire logic                       sys_rst_i, // sync reset
    input  wire logic                       ce_i,      // clock enable
    input  wire logic signed [15:0]         smp_i,     // input sample
    input  wire logic signed [12:0]         off_i,     // offset in lsb
    output logic signed [15:0]              smp_o      // shifted sample
);
    logic signed [16:0] sum;

    // offset added in converter lsb units
    assign sum = {smp_i[15], smp_i} + {{4{off_i[12]}}, off_i};

    // saturate into the sample range
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            smp_o <= '0;
        end else if (ce_i) begin
            if (sum > 17'(iq_corr_pkg::SMP_MAX)) begin
                smp_o <= iq_corr_pkg::SMP_MAX;
            end else if (sum < 17'(iq_corr_pkg::SMP_MIN)) begin
                smp_o <= iq_corr_pkg::SMP_MIN;
            end else begin
                smp_o <= sum[15:0];
            end
        end
    end
endmodule

// ---- rtl/iq_offset_gain_coarse_mix_regs.sv ----
// Function
// - channel c output gets 13-bit offset
// - channel d output gets 13-bit offset
// - writing offset c may raise auto-sync
// - auto-sync loads c and d offsets together
// - offset d write alone changes nothing applied
// - channel a scaled by 11-bit unsigned gain
// - channel b scaled by 11-bit unsigned gain
// - channel c scaled by 11-bit unsigned gain
// - gain is one integer, ten fraction bits
// - four coarse mix bits select shifts
// - set mix bits sum to n times fs/8
// - gains reset to unity, mixer to zero
// - offset c resets to zero
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module iq_offset_gain_coarse_mix_regs (
    input  wire logic               clk_sys_i,      // 200 mhz clock
    input  wire logic               sys_rst_i,      // sync reset, high
    input  wire logic               ce_i,           // clock enable
    input  wire logic [7:0]         reg_addr_i,     // register address
    input  wire logic [15:0]        reg_wdata_i,    // write data
    input  wire logic               reg_wr_i,       // write strobe
    input  wire logic               reg_rd_i,       // read strobe
    output logic [15:0]             reg_rdata_o,    // read data, +1 cycle
    input  wire logic               auto_sync_en_i, // auto-sync enable
    input  wire logic               sync_i,         // external load pulse
    input  wire logic signed [15:0] smp_a_i,        // channel a sample
    input  wire logic signed [15:0] smp_b_i,        // channel b sample
    input  wire logic signed [15:0] smp_c_i,        // channel c sample
    input  wire logic signed [15:0] smp_d_i,        // channel d sample
    output logic signed [15:0]      smp_a_o,        // corrected a
    output logic signed [15:0]      smp_b_o,        // corrected b
    output logic signed [15:0]      smp_c_o,        // corrected c
    output logic signed [15:0]      smp_d_o,        // corrected d
    output logic [3:0]              cmix_mode_o,    // coarse mix bits
    output logic [2:0]              cmix_shift_o    // total shift, fs/8
);
    localparam int OW = iq_corr_pkg::OFF_W;
    localparam int GW = iq_corr_pkg::GAIN_W;
    localparam int NC = iq_corr_pkg::NCH;

    // stored register fields
    logic [OW-1:0]  offset_c_value_r;
    logic [OW-1:0]  offset_d_value_r;
    logic [GW-1:0]  gain_a_factor_r;
    logic [GW-1:0]  gain_b_factor_r;
    logic [GW-1:0]  gain_c_factor_r;
    logic [3:0]     cmix_mode_r;
    // offsets applied to the datapath
    logic [OW-1:0]  act_off_c_r;
    logic [OW-1:0]  act_off_d_r;
    // decode
    logic           wr_off_c;
    logic           wr_off_d;
    logic           wr_gain_a;
    logic           wr_cmix_b;
    logic           wr_gain_c;
    logic           load_cd;
    logic [OW-1:0]  off_c_src;
    // readback and coarse mixer shift
    logic [15:0]    rd_mux;
    logic [15:0]    rdata_r;
    logic [2:0]     shift_nxt;
    logic [2:0]     shift_r;
    // per channel datapath
    logic signed [15:0] smp_in  [NC];
    logic signed [15:0] smp_gn  [NC];
    logic signed [15:0] smp_out [NC];
    logic [GW-1:0]      gain_v  [NC];
    logic [OW-1:0]      off_v   [NC];

    // write address decode
    assign wr_off_c  = reg_wr_i && reg_addr_i == iq_corr_pkg::ADDR_OFF_C;
    assign wr_off_d  = reg_wr_i && reg_addr_i == iq_corr_pkg::ADDR_OFF_D;
    assign wr_gain_a = reg_wr_i && reg_addr_i == iq_corr_pkg::ADDR_GAIN_A;
    assign wr_cmix_b = reg_wr_i
                       && reg_addr_i == iq_corr_pkg::ADDR_CMIX_GAIN_B;
    assign wr_gain_c = reg_wr_i && reg_addr_i == iq_corr_pkg::ADDR_GAIN_C;

    // offset registers, reserved bits never stored
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            offset_c_value_r <= iq_corr_pkg::OFF_RST;
            offset_d_value_r <= iq_corr_pkg::OFF_RST;
        end else if (ce_i) begin
            if (wr_off_c) begin
                offset_c_value_r <= reg_wdata_i[iq_corr_pkg::OFF_MSB:0];
            end
            if (wr_off_d) begin
                offset_d_value_r <= reg_wdata_i[iq_corr_pkg::OFF_MSB:0];
            end
        end
    end

    // gain and coarse mix registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            gain_a_factor_r <= iq_corr_pkg::GAIN_RST;
            gain_b_factor_r <= iq_corr_pkg::GAIN_RST;
            gain_c_factor_r <= iq_corr_pkg::GAIN_RST;
            cmix_mode_r     <= iq_corr_pkg::CMIX_RST;
        end else if (ce_i) begin
            if (wr_gain_a) begin
                gain_a_factor_r <= reg_wdata_i[iq_corr_pkg::GAIN_MSB:0];
            end
            if (wr_cmix_b) begin
                gain_b_factor_r <= reg_wdata_i[iq_corr_pkg::GAIN_MSB:0];
                cmix_mode_r     <= reg_wdata_i[iq_corr_pkg::CMIX_MSB:
                                               iq_corr_pkg::CMIX_LSB];
            end
            if (wr_gain_c) begin
                gain_c_factor_r <= reg_wdata_i[iq_corr_pkg::GAIN_MSB:0];
            end
        end
    end

    // joint load of the c/d pair: auto-sync write or external sync
    assign load_cd   = (wr_off_c && auto_sync_en_i) || sync_i;
    assign off_c_src = wr_off_c ? reg_wdata_i[iq_corr_pkg::OFF_MSB:0]
                                : offset_c_value_r;

    // applied offsets move only on a load, both in the same edge
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            act_off_c_r <= iq_corr_pkg::OFF_RST;
            act_off_d_r <= iq_corr_pkg::OFF_RST;
        end else if (ce_i && load_cd) begin
            act_off_c_r <= off_c_src;
            act_off_d_r <= offset_d_value_r;
        end
    end

    // coarse mixer: sum of the enabled shifts, modulo 8
    always_comb begin
        shift_nxt = iq_corr_pkg::SHIFT_NONE;
        if (cmix_mode_r[iq_corr_pkg::CMIX_FS8]) begin
            shift_nxt = shift_nxt + iq_corr_pkg::W_FS8;
        end
        if (cmix_mode_r[iq_corr_pkg::CMIX_FS4]) begin
            shift_nxt = shift_nxt + iq_corr_pkg::W_FS4;
        end
        if (cmix_mode_r[iq_corr_pkg::CMIX_FS2]) begin
            shift_nxt = shift_nxt + iq_corr_pkg::W_FS2;
        end
        if (cmix_mode_r[iq_corr_pkg::CMIX_NFS4]) begin
            shift_nxt = shift_nxt + iq_corr_pkg::W_NFS4;
        end
    end

    // registered mixer outputs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            shift_r <= iq_corr_pkg::SHIFT_NONE;
        end else if (ce_i) begin
            shift_r <= shift_nxt;
        end
    end

    // channel vectors: d keeps unity gain, a and b no offset
    assign smp_in[iq_corr_pkg::CH_A] = smp_a_i;
    assign smp_in[iq_corr_pkg::CH_B] = smp_b_i;
    assign smp_in[iq_corr_pkg::CH_C] = smp_c_i;
    assign smp_in[iq_corr_pkg::CH_D] = smp_d_i;
    assign gain_v[iq_corr_pkg::CH_A] = gain_a_factor_r;
    assign gain_v[iq_corr_pkg::CH_B] = gain_b_factor_r;
    assign gain_v[iq_corr_pkg::CH_C] = gain_c_factor_r;
    assign gain_v[iq_corr_pkg::CH_D] = iq_corr_pkg::GAIN_RST;
    assign off_v[iq_corr_pkg::CH_A]  = iq_corr_pkg::OFF_RST;
    assign off_v[iq_corr_pkg::CH_B]  = iq_corr_pkg::OFF_RST;
    assign off_v[iq_corr_pkg::CH_C]  = act_off_c_r;
    assign off_v[iq_corr_pkg::CH_D]  = act_off_d_r;

    // two stage pipe per channel: gain, then offset
    for (genvar ch = 0; ch < NC; ch++) begin : g_ch
        gain_scale u_gain (
            .clk_sys_i (clk_sys_i),
            .sys_rst_i (sys_rst_i),
            .ce_i      (ce_i),
            .smp_i     (smp_in[ch]),
            .gain_i    (gain_v[ch]),
            .smp_o     (smp_gn[ch])
        );
        offset_sat u_off (
            .clk_sys_i (clk_sys_i),
            .sys_rst_i (sys_rst_i),
            .ce_i      (ce_i),
            .smp_i     (smp_gn[ch]),
            .off_i     ($signed(off_v[ch])),
            .smp_o     (smp_out[ch])
        );
    end

    assign smp_a_o = smp_out[iq_corr_pkg::CH_A];
    assign smp_b_o = smp_out[iq_corr_pkg::CH_B];
    assign smp_c_o = smp_out[iq_corr_pkg::CH_C];
    assign smp_d_o = smp_out[iq_corr_pkg::CH_D];

    // read mux, reserved bits and unmapped addresses read zero
    always_comb begin
        rd_mux = iq_corr_pkg::RD_ZERO;
        unique case (reg_addr_i)
            iq_corr_pkg::ADDR_OFF_C: begin
                rd_mux[iq_corr_pkg::OFF_MSB:0] = offset_c_value_r;
            end
            iq_corr_pkg::ADDR_OFF_D: begin
                rd_mux[iq_corr_pkg::OFF_MSB:0] = offset_d_value_r;
            end
            iq_corr_pkg::ADDR_GAIN_A: begin
                rd_mux[iq_corr_pkg::GAIN_MSB:0] = gain_a_factor_r;
            end
            iq_corr_pkg::ADDR_CMIX_GAIN_B: begin
                rd_mux[iq_corr_pkg::GAIN_MSB:0] = gain_b_factor_r;
                rd_mux[iq_corr_pkg::CMIX_MSB:iq_corr_pkg::CMIX_LSB] =
                    cmix_mode_r;
            end
            iq_corr_pkg::ADDR_GAIN_C: begin
                rd_mux[iq_corr_pkg::GAIN_MSB:0] = gain_c_factor_r;
            end
            default: begin
                rd_mux = iq_corr_pkg::RD_ZERO;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_r <= iq_corr_pkg::RD_ZERO;
        end else if (ce_i) begin
            rdata_r <= reg_rd_i ? rd_mux : iq_corr_pkg::RD_ZERO;
        end
    end

    assign reg_rdata_o  = rdata_r;
    assign cmix_mode_o  = cmix_mode_r;
    assign cmix_shift_o = shift_r;

    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_sync_wr_c;
        ce_i && wr_off_c && auto_sync_en_i;
    endsequence

    sequence s_wr_d_only;
        ce_i && wr_off_d && !load_cd;
    endsequence

    sequence s_quiet_c;
        ce_i && gain_c_factor_r == iq_corr_pkg::GAIN_RST
            && act_off_c_r == iq_corr_pkg::OFF_RST;
    endsequence

    autosync_load_a: assert property (
        s_sync_wr_c |=> act_off_c_r == $past(reg_wdata_i[12:0])
                        && act_off_d_r == $past(offset_d_value_r))
        else $error("auto-sync did not load both offsets");

    d_write_hold_a: assert property (
        s_wr_d_only |=> $stable(act_off_d_r) && $stable(act_off_c_r)
                        && offset_d_value_r == $past(reg_wdata_i[12:0]))
        else $error("offset d write changed applied offset");

    gain_reset_a: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        sys_rst_i |=> gain_a_factor_r == 11'h400
                      && gain_b_factor_r == 11'h400
                      && gain_c_factor_r == 11'h400
                      && cmix_mode_o == 4'h0)
        else $error("gain or mixer reset value wrong");

    offc_reset_a: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        sys_rst_i |=> offset_c_value_r == 13'h0000
                      && act_off_c_r == 13'h0000)
        else $error("offset c reset value wrong");

    rsvd_read_a: assert property (
        ce_i && reg_rd_i && reg_addr_i != iq_corr_pkg::ADDR_CMIX_GAIN_B
        |=> reg_rdata_o[15:13] == 3'h0)
        else $error("reserved bits read nonzero");

    rdata_idle_a: assert property (
        ce_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside the read slot");

    mix_total_a: assert property (
        ce_i |=> cmix_shift_o == 3'($past(cmix_mode_r[3])
                 + 2 * $past(cmix_mode_r[2]) + 4 * $past(cmix_mode_r[1])
                 + 6 * $past(cmix_mode_r[0])))
        else $error("coarse mix total wrong");

    unity_c_a: assert property (
        s_quiet_c ##1 s_quiet_c |=> smp_c_o == $past(smp_c_i, 2))
        else $error("unity gain zero offset changed channel c");

    offset_d_a: assert property (
        ce_i && $stable(act_off_d_r) && smp_gn[3] > -16'sh6000
        && smp_gn[3] < 16'sh6000
        |=> smp_d_o == $past(smp_gn[3]) + $past({{3{act_off_d_r[12]}},
                                                  act_off_d_r}))
        else $error("channel d offset not applied");

    gain_half_a: assert property (
        ce_i && gain_a_factor_r == 11'h200 && smp_a_i == 16'sh0400
        |=> smp_gn[0] == 16'sh0200)
        else $error("channel a gain scaling wrong");

    // c/d offset loads and the plain stores
    sync_load_a: assert property (
        ce_i && sync_i && !wr_off_c
        |=> act_off_c_r == $past(offset_c_value_r)
            && act_off_d_r == $past(offset_d_value_r))
        else $error("sync pulse did not load both offsets");

    c_store_only_a: assert property (
        ce_i && wr_off_c && !auto_sync_en_i && !sync_i
        |=> $stable(act_off_c_r) && $stable(act_off_d_r)
            && offset_c_value_r == $past(reg_wdata_i[12:0]))
        else $error("offset c write without auto-sync loaded");

    offd_reset_a: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        sys_rst_i |=> offset_d_value_r == 13'h0000
                      && act_off_d_r == 13'h0000)
        else $error("offset d reset value wrong");

    // gain and mixer writes land, reads show only the field
    gain_a_write_a: assert property (
        ce_i && wr_gain_a
        |=> gain_a_factor_r == $past(reg_wdata_i[10:0]))
        else $error("gain a write not stored");

    gain_b_write_a: assert property (
        ce_i && wr_cmix_b
        |=> gain_b_factor_r == $past(reg_wdata_i[10:0])
            && cmix_mode_r == $past(reg_wdata_i[15:12]))
        else $error("gain b or mixer write not stored");

    gain_c_write_a: assert property (
        ce_i && wr_gain_c
        |=> gain_c_factor_r == $past(reg_wdata_i[10:0]))
        else $error("gain c write not stored");

    gain_read_a: assert property (
        ce_i && reg_rd_i && reg_addr_i == iq_corr_pkg::ADDR_GAIN_C
        |=> reg_rdata_o == {5'h00, $past(gain_c_factor_r)})
        else $error("gain c read shows reserved bits");
endmodule

// ---- dv/iq_offset_gain_coarse_mix_regs_test.sv ----
`timescale 1ns/1ps
module iq_offset_gain_coarse_mix_regs_test;
    logic               clk_sys_i;
    logic               sys_rst_i;
    logic               ce_i;
    logic [7:0]         reg_addr_i;
    logic [15:0]        reg_wdata_i;
    logic               reg_wr_i;
    logic               reg_rd_i;
    logic [15:0]        reg_rdata_o;
    logic               auto_sync_en_i;
    logic               sync_i;
    logic signed [15:0] smp_a_i, smp_b_i, smp_c_i, smp_d_i;
    logic signed [15:0] smp_a_o, smp_b_o, smp_c_o, smp_d_o;
    logic [3:0]         cmix_mode_o;
    logic [2:0]         cmix_shift_o;
    int                 fails;
    int                 n_checks;
    logic               rd_pend;
    logic [15:0]        rd_exp;
    logic [2:0]         sh;

    typedef struct {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
    } row_t;

    // write, then read back: reserved bits drop, unmapped reads zero
    row_t rows [9] = '{
        '{8'h0A, 16'hFFFF, 16'h1FFF}, '{8'h0B, 16'hFFFF, 16'h1FFF},
        '{8'h0C, 16'hFFFF, 16'h07FF}, '{8'h0D, 16'hFFFF, 16'hF7FF},
        '{8'h0E, 16'hFFFF, 16'h07FF}, '{8'h0F, 16'h1234, 16'h0000},
        '{8'h09, 16'h1234, 16'h0000}, '{8'h00, 16'hFFFF, 16'h0000},
        '{8'h0D, 16'hA555, 16'hA555}};

    iq_offset_gain_coarse_mix_regs i_iq_offset_gain_coarse_mix_regs (
        .clk_sys_i      (clk_sys_i),
        .sys_rst_i      (sys_rst_i),
        .ce_i           (ce_i),
        .reg_addr_i     (reg_addr_i),
        .reg_wdata_i    (reg_wdata_i),
        .reg_wr_i       (reg_wr_i),
        .reg_rd_i       (reg_rd_i),
        .reg_rdata_o    (reg_rdata_o),
        .auto_sync_en_i (auto_sync_en_i),
        .sync_i         (sync_i),
        .smp_a_i        (smp_a_i),
        .smp_b_i        (smp_b_i),
        .smp_c_i        (smp_c_i),
        .smp_d_i        (smp_d_i),
        .smp_a_o        (smp_a_o),
        .smp_b_o        (smp_b_o),
        .smp_c_o        (smp_c_o),
        .smp_d_o        (smp_d_o),
        .cmix_mode_o    (cmix_mode_o),
        .cmix_shift_o   (cmix_shift_o)
    );

    // 200 mhz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // expected sample: saturate gain product, add offset, saturate again
    function automatic logic [15:0] fix(input logic signed [15:0] s,
                                        input logic [10:0] g,
                                        input logic signed [12:0] o);
        logic signed [31:0] p;
        p = (s * $signed({1'b0, g})) >>> 10;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        p = p + o;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr_i    <= 1'b1;
        reg_rd_i    <= 1'b0;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_rd_i   <= 1'b1;
        reg_wr_i   <= 1'b0;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        rd_exp  <= e;
        rd_pend <= 1'b1;
    endtask

    task automatic idle(input int n);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        sync_i   <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic outs(input logic [15:0] ea, eb, ec, ed);
        @(negedge clk_sys_i);
        check(smp_a_o, ea);
        check(smp_b_o, eb);
        check(smp_c_o, ec);
        check(smp_d_o, ed);
        @(posedge clk_sys_i);
    endtask

    // read data is looked at in the one cycle it stands
    always @(negedge clk_sys_i) begin
        if (rd_pend) begin
            check(reg_rdata_o, rd_exp);
            rd_pend <= 1'b0;
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        conclude();
    end

    // main sequence
    initial begin
        fails = 0;
        n_checks = 0;
        rd_pend = 1'b0;
        rd_exp = 16'h0000;
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        auto_sync_en_i = 1'b0;
        sync_i = 1'b0;
        smp_a_i = 16'sh1000;
        smp_b_i = 16'sh1000;
        smp_c_i = 16'sh1000;
        smp_d_i = 16'sh1000;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        idle(1);
        @(negedge clk_sys_i);
        check({12'h000, cmix_mode_o}, 16'h0000);
        check({13'h0000, cmix_shift_o}, 16'h0000);
        @(posedge clk_sys_i);
        rd(8'h0A, 16'h0000);
        rd(8'h0B, 16'h0000);
        rd(8'h0C, 16'h0400);
        rd(8'h0D, 16'h0400);
        rd(8'h0E, 16'h0400);
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
        end
        // every coarse mix code, total shift in eighths modulo 8
        for (int m = 0; m < 16; m++) begin
            wr(8'h0D, {m[3:0], 12'h400});
            idle(3);
            sh = (m[3] ? 3'h1 : 3'h0) + (m[2] ? 3'h2 : 3'h0)
               + (m[1] ? 3'h4 : 3'h0) + (m[0] ? 3'h6 : 3'h0);
            @(negedge clk_sys_i);
            check({12'h000, cmix_mode_o}, {12'h000, m[3:0]});
            check({13'h0000, cmix_shift_o}, {13'h0000, sh});
            @(posedge clk_sys_i);
        end
        wr(8'h0C, 16'h0200);
        wr(8'h0D, 16'h07FF);
        wr(8'h0E, 16'h0400);
        auto_sync_en_i <= 1'b1;
        wr(8'h0B, 16'h0005);
        idle(4);
        // stored offsets not yet applied
        outs(16'h0800, fix(16'sh1000, 11'h7FF, 13'sh0000),
             16'h1000, 16'h1000);
        wr(8'h0A, 16'h0003);
        idle(4);
        outs(16'h0800, 16'h1FFC, 16'h1003, 16'h1005);
        auto_sync_en_i <= 1'b0;
        wr(8'h0B, 16'h1FFF);
        wr(8'h0A, 16'h1FFE);
        idle(4);
        outs(16'h0800, 16'h1FFC, 16'h1003, 16'h1005);
        sync_i   <= 1'b1;
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
        idle(4);
        outs(16'h0800, 16'h1FFC, 16'h0FFE, 16'h0FFF);
        // saturating gain paths on b and c
        smp_a_i <= 16'sh0400;
        smp_b_i <= 16'sh8000;
        smp_c_i <= 16'sh7000;
        wr(8'h0E, 16'h07FF);
        idle(4);
        outs(16'h0200, fix(16'sh8000, 11'h7FF, 13'sh0000),
             fix(16'sh7000, 11'h7FF, -13'sh0002), 16'h0FFF);
        // write while clock enable is low is not taken
        ce_i <= 1'b0;
        wr(8'h0C, 16'h0123);
        ce_i <= 1'b1;
        rd(8'h0C, 16'h0200);
        // reset in mid-run restores defaults
        sys_rst_i <= 1'b1;
        idle(2);
        sys_rst_i <= 1'b0;
        idle(1);
        rd(8'h0C, 16'h0400);
        rd(8'h0A, 16'h0000);
        idle(4);
        outs(16'h0400, 16'h8000, 16'h7000, 16'h1000);
        conclude();
    end
endmodule
